// File: adcc_top.sv
// register block and sequencing for the 12-bit converter control
// Functional notes
// - a conversion starts only when the start bit is written high then low.
// - busy flag sets at launch, clears at completion; writes to it ignored.
// - converter enable zero powers the core off; one powers it.
// - while disabled both result bytes keep the last result.
// - justification bit chooses left or right placement of the 12-bit result.
// - four-bit channel code selects external input of the same index.
// - source field routes external, bandgap, temperature, amplifiers or line.
// - reference field selects external pin, analog supply or sensor reference.
// - clock field divides the system clock by two to its power.
// - mode bit selects normal mode at zero, low-current mode at one.
// - reserved mode register bit one resets to one; software writes one.
// - unimplemented bits of mode and bandgap registers read zero.
// - bandgap enable drives the bandgap; zero leaves its output undriven.
// - a pin chosen as converter input loses other function and pull-up.
// - unused positions of result bytes read zero.
// - completion clearing busy raises the converter interrupt request.
module adcc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adcc_pkg::DATA_W-1:0] reg_rdata,
  output logic core_power_on,
  output logic core_start,
  output logic core_conv_clk_en,
  output adcc_pkg::adcc_core_cfg_t core_cfg,
  output adcc_pkg::adcc_route_t core_route,
  output adcc_pkg::adcc_ref_t core_ref,
  output logic [adcc_pkg::CHAN_N-1:0] ext_chan_onehot,
  output logic bandgap_out_en,
  input wire logic core_done,
  input wire logic [adcc_pkg::RESULT_W-1:0] core_result,
  input wire logic [adcc_pkg::CHAN_N-1:0] pin_analog_sel,
  output logic [adcc_pkg::CHAN_N-1:0] pin_func_release,
  output logic [adcc_pkg::CHAN_N-1:0] pin_pullup_off,
  output logic conv_irq_req
);

  // -------------------------------------------------------------------------
  // state and storage
  // -------------------------------------------------------------------------
  typedef enum logic {
    ADCC_IDLE,
    ADCC_BUSY
  } adcc_state_t;

  adcc_state_t state;
  adcc_state_t next_state;

  logic start_bit;
  logic converter_enable;
  logic result_justify_sel;
  logic [adcc_pkg::CHAN_W-1:0] ext_channel_sel;
  logic [adcc_pkg::SRC_W-1:0] input_source_sel;
  logic [adcc_pkg::REF_W-1:0] reference_sel;
  logic [adcc_pkg::DIV_W-1:0] conv_clock_div_sel;
  logic conv_mode_sel;
  logic reserved_fixed_one;
  logic temp_sensor_enable;
  logic bandgap_enable;
  logic [adcc_pkg::RESULT_W-1:0] result_raw;

  logic wr_primary;
  logic wr_secondary;
  logic wr_mode;
  logic wr_bandgap;
  logic launch;
  logic finish;
  logic conv_busy_flag;
  logic [adcc_pkg::SRC_W-1:0] src_wr;
  logic [adcc_pkg::DATA_W-1:0] adc_result_high;
  logic [adcc_pkg::DATA_W-1:0] adc_result_low;
  logic [adcc_pkg::DATA_W-1:0] next_rdata;

  // -------------------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------------------
  always_comb begin
    wr_primary = reg_wr && (reg_addr == adcc_pkg::OFS_CTRL_PRIMARY);
    wr_secondary = reg_wr && (reg_addr == adcc_pkg::OFS_CTRL_SECONDARY);
    wr_mode = reg_wr && (reg_addr == adcc_pkg::OFS_MODE_SENSOR);
    wr_bandgap = reg_wr && (reg_addr == adcc_pkg::OFS_BANDGAP);
    src_wr = reg_wdata[adcc_pkg::SRC_LSB +: adcc_pkg::SRC_W];
  end

  // start bit written low while it stood high, converter on and idle
  always_comb begin
    launch = wr_primary && start_bit
             && !reg_wdata[adcc_pkg::START_BIT]
             && converter_enable
             && (state == ADCC_IDLE);
  end

  // completion counts only for a running conversion of a powered core
  always_comb begin
    finish = (state == ADCC_BUSY) && core_done && converter_enable;
  end

  // -------------------------------------------------------------------------
  // primary control register
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_bit <= adcc_pkg::PRIMARY_RST[adcc_pkg::START_BIT];
      converter_enable <= adcc_pkg::PRIMARY_RST[adcc_pkg::ENABLE_BIT];
      result_justify_sel <= adcc_pkg::PRIMARY_RST[adcc_pkg::JUSTIFY_BIT];
      ext_channel_sel <=
        adcc_pkg::PRIMARY_RST[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W];
    end else if (wr_primary) begin
      start_bit <= reg_wdata[adcc_pkg::START_BIT];
      converter_enable <= reg_wdata[adcc_pkg::ENABLE_BIT];
      result_justify_sel <= reg_wdata[adcc_pkg::JUSTIFY_BIT];
      ext_channel_sel <=
        reg_wdata[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W];
    end
  end

  // -------------------------------------------------------------------------
  // secondary control register
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      input_source_sel <=
        adcc_pkg::SECONDARY_RST[adcc_pkg::SRC_LSB +: adcc_pkg::SRC_W];
      reference_sel <=
        adcc_pkg::SECONDARY_RST[adcc_pkg::REF_LSB +: adcc_pkg::REF_W];
      conv_clock_div_sel <=
        adcc_pkg::SECONDARY_RST[adcc_pkg::DIV_LSB +: adcc_pkg::DIV_W];
    end else if (wr_secondary) begin
      // the forbidden source code never lands in the field
      if (src_wr != adcc_pkg::SRC_FORBIDDEN) begin
        input_source_sel <= src_wr;
      end
      reference_sel <=
        reg_wdata[adcc_pkg::REF_LSB +: adcc_pkg::REF_W];
      conv_clock_div_sel <=
        reg_wdata[adcc_pkg::DIV_LSB +: adcc_pkg::DIV_W];
    end
  end

  // -------------------------------------------------------------------------
  // mode, sensor and bandgap registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_mode_sel <= adcc_pkg::MODE_SENSOR_RST[adcc_pkg::MODE_BIT];
      reserved_fixed_one <=
        adcc_pkg::MODE_SENSOR_RST[adcc_pkg::RSVD_BIT];
      temp_sensor_enable <= adcc_pkg::MODE_SENSOR_RST[adcc_pkg::TEMP_SENSOR_ENABLE_BIT];
    end else if (wr_mode) begin
      conv_mode_sel <= reg_wdata[adcc_pkg::MODE_BIT];
      reserved_fixed_one <= reg_wdata[adcc_pkg::RSVD_BIT];
      temp_sensor_enable <= reg_wdata[adcc_pkg::TEMP_SENSOR_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bandgap_enable <= adcc_pkg::BANDGAP_RST[adcc_pkg::BG_BIT];
    end else if (wr_bandgap) begin
      bandgap_enable <= reg_wdata[adcc_pkg::BG_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // conversion sequencer
  // -------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ADCC_IDLE: begin
        if (launch) begin
          next_state = ADCC_BUSY;
        end
      end
      ADCC_BUSY: begin
        // switching the converter off abandons the conversion
        if (finish || !converter_enable) begin
          next_state = ADCC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ADCC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    conv_busy_flag = (state == ADCC_BUSY);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_start <= 1'b0;
    end else begin
      core_start <= launch;
    end
  end

  // completion pulse towards the interrupt controller
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_irq_req <= 1'b0;
    end else begin
      conv_irq_req <= finish;
    end
  end

  // -------------------------------------------------------------------------
  // result capture
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_raw <= adcc_pkg::RESULT_RST;
    end else if (finish) begin
      result_raw <= core_result;
    end
  end

  adcc_result_fmt u_fmt (
    .justify(result_justify_sel),
    .result(result_raw),
    .byte_high(adc_result_high),
    .byte_low(adc_result_low)
  );

  // -------------------------------------------------------------------------
  // converter clock
  // -------------------------------------------------------------------------
  adcc_clk_div #(
    .CNT_W(adcc_pkg::DIV_CNT_W)
  ) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .run(converter_enable),
    .div_sel(conv_clock_div_sel),
    .tick(core_conv_clk_en)
  );

  // -------------------------------------------------------------------------
  // settings and routing towards the analog core
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_power_on <= 1'b0;
      bandgap_out_en <= 1'b0;
      core_cfg <= '0;
    end else begin
      core_power_on <= converter_enable;
      bandgap_out_en <= bandgap_enable;
      core_cfg.converter_enable <= converter_enable;
      core_cfg.ext_channel_sel <= ext_channel_sel;
      core_cfg.input_source_sel <= input_source_sel;
      core_cfg.reference_sel <= reference_sel;
      core_cfg.conv_clock_div_sel <= conv_clock_div_sel;
      core_cfg.conv_mode_sel <= conv_mode_sel;
      core_cfg.temp_sensor_enable <= temp_sensor_enable;
      core_cfg.bandgap_enable <= bandgap_enable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_route <= '0;
    end else begin
      core_route <= '0;
      unique case (input_source_sel)
        adcc_pkg::SRC_EXT_A, adcc_pkg::SRC_EXT_B: begin
          core_route.ext_channel <= 1'b1;
        end
        adcc_pkg::SRC_BANDGAP: begin
          core_route.bandgap_voltage <= 1'b1;
        end
        adcc_pkg::SRC_TEMP: begin
          core_route.temp_sensor_output <= 1'b1;
        end
        adcc_pkg::SRC_AMP0: begin
          core_route.sense_amp0_output <= 1'b1;
        end
        adcc_pkg::SRC_AMP1: begin
          core_route.sense_amp1_output <= 1'b1;
        end
        adcc_pkg::SRC_LINE: begin
          core_route.line_amp_output <= 1'b1;
        end
        default: begin
          core_route <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_ref <= '0;
    end else begin
      core_ref <= '0;
      unique case (reference_sel)
        adcc_pkg::REF_EXT_PIN: begin
          core_ref.ext_pin <= 1'b1;
        end
        adcc_pkg::REF_SUPPLY_A, adcc_pkg::REF_SUPPLY_B: begin
          core_ref.analog_supply <= 1'b1;
        end
        adcc_pkg::REF_TEMP: begin
          core_ref.temp_sensor_reference <= 1'b1;
        end
      endcase
    end
  end

  // one select line per external input, live only on external routing
  for (genvar i = 0; i < adcc_pkg::CHAN_N; i++) begin : g_chan
    always_ff @(posedge core_clk) begin
      if (rst) begin
        ext_chan_onehot[i] <= 1'b0;
      end else begin
        ext_chan_onehot[i] <=
          (ext_channel_sel == adcc_pkg::CHAN_W'(i))
          && ((input_source_sel == adcc_pkg::SRC_EXT_A)
          || (input_source_sel == adcc_pkg::SRC_EXT_B));
      end
    end
  end

  // pins taken as converter inputs drop their other function and pull-up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_func_release <= '0;
      pin_pullup_off <= '0;
    end else begin
      pin_func_release <= pin_analog_sel;
      pin_pullup_off <= pin_analog_sel;
    end
  end

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr)
      adcc_pkg::OFS_RESULT_HIGH: begin
        next_rdata = adc_result_high;
      end
      adcc_pkg::OFS_RESULT_LOW: begin
        next_rdata = adc_result_low;
      end
      adcc_pkg::OFS_CTRL_PRIMARY: begin
        next_rdata[adcc_pkg::START_BIT] = start_bit;
        next_rdata[adcc_pkg::BUSY_BIT] = conv_busy_flag;
        next_rdata[adcc_pkg::ENABLE_BIT] = converter_enable;
        next_rdata[adcc_pkg::JUSTIFY_BIT] = result_justify_sel;
        next_rdata[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W] = ext_channel_sel;
      end
      adcc_pkg::OFS_CTRL_SECONDARY: begin
        next_rdata[adcc_pkg::SRC_LSB +: adcc_pkg::SRC_W] = input_source_sel;
        next_rdata[adcc_pkg::REF_LSB +: adcc_pkg::REF_W] = reference_sel;
        next_rdata[adcc_pkg::DIV_LSB +: adcc_pkg::DIV_W] = conv_clock_div_sel;
      end
      adcc_pkg::OFS_MODE_SENSOR: begin
        next_rdata[adcc_pkg::MODE_BIT] = conv_mode_sel;
        next_rdata[adcc_pkg::RSVD_BIT] = reserved_fixed_one;
        next_rdata[adcc_pkg::TEMP_SENSOR_ENABLE_BIT] = temp_sensor_enable;
      end
      adcc_pkg::OFS_BANDGAP: begin
        next_rdata[adcc_pkg::BG_BIT] = bandgap_enable;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// File: adcc_pkg.sv
// constants, encodings and carrier types shared by the converter control block
package adcc_pkg;

  // -------------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RESULT_W = 12;
  localparam int CHAN_N = 16;
  localparam int CHAN_W = 4;
  localparam int SRC_W = 3;
  localparam int REF_W = 2;
  localparam int DIV_W = 3;
  localparam int DIV_CNT_W = 7;

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL_PRIMARY = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL_SECONDARY = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_MODE_SENSOR = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_BANDGAP = 3'h5;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int ENABLE_BIT = 5;
  localparam int JUSTIFY_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int SRC_LSB = 5;
  localparam int REF_LSB = 3;
  localparam int DIV_LSB = 0;
  localparam int MODE_BIT = 7;
  localparam int RSVD_BIT = 1;
  localparam int TEMP_SENSOR_ENABLE_BIT = 0;
  localparam int BG_BIT = 0;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] PRIMARY_RST = 8'h00;
  localparam logic [DATA_W-1:0] SECONDARY_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODE_SENSOR_RST = 8'h02;
  localparam logic [DATA_W-1:0] BANDGAP_RST = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  // -------------------------------------------------------------------------
  // input source and reference encodings
  // -------------------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_EXT_A = 3'h0;
  localparam logic [SRC_W-1:0] SRC_BANDGAP = 3'h1;
  localparam logic [SRC_W-1:0] SRC_TEMP = 3'h2;
  localparam logic [SRC_W-1:0] SRC_AMP0 = 3'h3;
  localparam logic [SRC_W-1:0] SRC_AMP1 = 3'h4;
  localparam logic [SRC_W-1:0] SRC_LINE = 3'h5;
  localparam logic [SRC_W-1:0] SRC_EXT_B = 3'h6;
  localparam logic [SRC_W-1:0] SRC_FORBIDDEN = 3'h7;

  localparam logic [REF_W-1:0] REF_EXT_PIN = 2'h0;
  localparam logic [REF_W-1:0] REF_SUPPLY_A = 2'h1;
  localparam logic [REF_W-1:0] REF_TEMP = 2'h2;
  localparam logic [REF_W-1:0] REF_SUPPLY_B = 2'h3;

  // -------------------------------------------------------------------------
  // carrier types
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic converter_enable;
    logic [CHAN_W-1:0] ext_channel_sel;
    logic [SRC_W-1:0] input_source_sel;
    logic [REF_W-1:0] reference_sel;
    logic [DIV_W-1:0] conv_clock_div_sel;
    logic conv_mode_sel;
    logic temp_sensor_enable;
    logic bandgap_enable;
  } adcc_core_cfg_t;

  typedef struct packed {
    logic ext_channel;
    logic bandgap_voltage;
    logic temp_sensor_output;
    logic sense_amp0_output;
    logic sense_amp1_output;
    logic line_amp_output;
  } adcc_route_t;

  typedef struct packed {
    logic ext_pin;
    logic analog_supply;
    logic temp_sensor_reference;
  } adcc_ref_t;

endpackage

// File: adcc_clk_div.sv
// power-of-two divider that makes the converter clock enable pulse
module adcc_clk_div #(
  parameter int CNT_W = adcc_pkg::DIV_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [adcc_pkg::DIV_W-1:0] div_sel,
  output logic tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W:0] full;
  logic [CNT_W-1:0] last;

  // divide by two raised to div_sel: last count is 2**sel - 1
  always_comb begin
    full = {{CNT_W{1'b0}}, 1'b1} << div_sel;
    last = CNT_W'(full - 1'b1);
  end

  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      cnt <= '0;
    end else if (cnt >= last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt >= last);
    end
  end

endmodule

// File: adcc_result_fmt.sv
// places the 12-bit result into the two data bytes per justification
module adcc_result_fmt (
  input wire logic justify,
  input wire logic [adcc_pkg::RESULT_W-1:0] result,
  output logic [adcc_pkg::DATA_W-1:0] byte_high,
  output logic [adcc_pkg::DATA_W-1:0] byte_low
);

  // unused positions are zero in both formats
  always_comb begin
    if (justify) begin
      byte_high = {4'h0, result[11:8]};
      byte_low = result[7:0];
    end else begin
      byte_high = result[11:4];
      byte_low = {result[3:0], 4'h0};
    end
  end

endmodule

// File: adcc_top_properties.sv
// concurrent checks on the ports of the converter control block
module adcc_top_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [adcc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic core_power_on,
  input wire logic core_start,
  input wire adcc_pkg::adcc_core_cfg_t core_cfg,
  input wire adcc_pkg::adcc_route_t core_route,
  input wire adcc_pkg::adcc_ref_t core_ref,
  input wire logic [adcc_pkg::CHAN_N-1:0] ext_chan_onehot,
  input wire logic bandgap_out_en,
  input wire logic core_done,
  input wire logic [adcc_pkg::CHAN_N-1:0] pin_analog_sel,
  input wire logic [adcc_pkg::CHAN_N-1:0] pin_func_release,
  input wire logic [adcc_pkg::CHAN_N-1:0] pin_pullup_off,
  input wire logic conv_irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_start;
    core_start |-> $past(reg_wr) && !$past(reg_wdata[adcc_pkg::START_BIT])
      && $past(reg_addr) == adcc_pkg::OFS_CTRL_PRIMARY;
  endproperty
  a_start: assert property (p_start) else $error("start without launch");
  property p_irq;
    conv_irq_req |-> $past(core_done) && !core_start;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without done");
  property p_power;
    core_power_on == core_cfg.converter_enable;
  endproperty
  a_power: assert property (p_power) else $error("power mismatch");
  property p_chan;
    core_route.ext_channel |->
      ext_chan_onehot == (16'h0001 << core_cfg.ext_channel_sel);
  endproperty
  a_chan: assert property (p_chan) else $error("channel onehot wrong");
  property p_src;
    core_cfg.input_source_sel != adcc_pkg::SRC_FORBIDDEN;
  endproperty
  a_src: assert property (p_src) else $error("forbidden source");
  property p_bg;
    bandgap_out_en == core_cfg.bandgap_enable;
  endproperty
  a_bg: assert property (p_bg) else $error("bandgap drive wrong");
  property p_refsel;
    core_cfg.reference_sel == adcc_pkg::REF_TEMP |-> core_ref == 3'b001;
  endproperty
  a_refsel: assert property (p_refsel) else $error("reference wrong");
  property p_pin;
    !$past(rst) |-> pin_func_release == $past(pin_analog_sel)
      && pin_pullup_off == $past(pin_analog_sel);
  endproperty
  a_pin: assert property (p_pin) else $error("pin release wrong");
  property p_rdata;
    !$past(rst) && (!$past(reg_rd) || $past(reg_addr) > 3'h5)
      |-> reg_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not zero");
  property p_mode;
    $past(reg_rd) && $past(reg_addr) == adcc_pkg::OFS_MODE_SENSOR
      |-> reg_rdata[6:2] == 5'h00;
  endproperty
  a_mode: assert property (p_mode) else $error("mode spare bits set");
endmodule

bind adcc_top adcc_top_chk u_chk (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_power_on(core_power_on),
  .core_start(core_start), .core_cfg(core_cfg), .core_route(core_route),
  .core_ref(core_ref), .ext_chan_onehot(ext_chan_onehot),
  .bandgap_out_en(bandgap_out_en), .core_done(core_done),
  .pin_analog_sel(pin_analog_sel), .pin_func_release(pin_func_release),
  .pin_pullup_off(pin_pullup_off), .conv_irq_req(conv_irq_req));

// File: test_adcc_top.sv
// register-level testbench for the converter control block
module test_adcc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, reg_wr, reg_rd, core_done;
  logic core_power_on, core_start, core_conv_clk_en, bandgap_out_en;
  logic conv_irq_req;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [11:0] core_result;
  logic [15:0] pin_analog_sel, ext_chan_onehot, pin_func_release;
  logic [15:0] pin_pullup_off;
  adcc_pkg::adcc_core_cfg_t core_cfg;
  adcc_pkg::adcc_route_t core_route;
  adcc_pkg::adcc_ref_t core_ref;
  int failures = 0;
  int num_checks = 0;
  int n;

  adcc_top u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_power_on(core_power_on),
    .core_start(core_start), .core_conv_clk_en(core_conv_clk_en),
    .core_cfg(core_cfg), .core_route(core_route), .core_ref(core_ref),
    .ext_chan_onehot(ext_chan_onehot), .bandgap_out_en(bandgap_out_en),
    .core_done(core_done), .core_result(core_result),
    .pin_analog_sel(pin_analog_sel), .pin_func_release(pin_func_release),
    .pin_pullup_off(pin_pullup_off), .conv_irq_req(conv_irq_req));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic done_pulse(input logic [11:0] r);
    @(posedge core_clk);
    core_done <= 1'b1;
    core_result <= r;
    @(posedge core_clk);
    core_done <= 1'b0;
    core_result <= ~r;
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, core_done, reg_addr, reg_wdata} = '0;
    core_result = 12'h000;
    pin_analog_sel = 16'h0000;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // ---------------------------------------------------------------
    // reset values, spare bits, unmapped places
    // ---------------------------------------------------------------
    for (int a = 0; a < 6; a++) rd(a[2:0], (a == 4) ? 8'h02 : 8'h00);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'h83);
    chk(core_cfg.conv_mode_sel, 1'b1);
    wr(3'h4, 8'h03);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h01);
    chk(bandgap_out_en, 1'b1);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h00);
    // ---------------------------------------------------------------
    // start sequence, busy, capture and justification
    // ---------------------------------------------------------------
    wr(3'h2, 8'hE0);
    #1 chk(core_start, 1'b0);
    rd(3'h2, 8'hA0);
    wr(3'h2, 8'hA0);
    #1 chk(core_start, 1'b0);
    wr(3'h2, 8'h20);
    #1 chk(core_start, 1'b1);
    rd(3'h2, 8'h60);
    done_pulse(12'hABC);
    #1 chk(conv_irq_req, 1'b1);
    rd(3'h2, 8'h20);
    rd(3'h0, 8'hAB);
    rd(3'h1, 8'hC0);
    wr(3'h2, 8'h30);
    rd(3'h0, 8'h0A);
    rd(3'h1, 8'hBC);
    // ---------------------------------------------------------------
    // disabled converter keeps its result and refuses to start
    // ---------------------------------------------------------------
    wr(3'h2, 8'hB0);
    wr(3'h2, 8'h30);
    #1 chk(core_start, 1'b1);
    wr(3'h2, 8'h90);
    wr(3'h2, 8'h10);
    #1 chk(core_start, 1'b0);
    chk(core_power_on, 1'b0);
    done_pulse(12'h123);
    rd(3'h1, 8'hBC);
    rd(3'h2, 8'h10);
    // ---------------------------------------------------------------
    // source and reference routing, forbidden source code
    // ---------------------------------------------------------------
    wr(3'h2, 8'h2F);
    for (int s = 0; s < 7; s++) begin
      wr(3'h3, {s[2:0], s[1:0], 3'h0});
      @(posedge core_clk);
      #1 chk(core_route, (s == 0 || s == 6) ? 6'h20 : 6'h20 >> s);
      chk(core_ref, (s[1:0] == 0) ? 3'h4 : (s[1:0] == 2) ? 3'h1 : 3'h2);
      chk(ext_chan_onehot, (s == 0 || s == 6) ? 16'h8000 : 16'h0000);
      chk(core_cfg.input_source_sel, s[2:0]);
    end
    wr(3'h3, 8'hE1);
    rd(3'h3, 8'hC1);
    // ---------------------------------------------------------------
    // clock divider rates
    // ---------------------------------------------------------------
    for (int d = 0; d < 8; d++) begin
      wr(3'h3, {5'h00, d[2:0]});
      repeat (130) @(posedge core_clk);
      n = 0;
      repeat (128) begin
        @(posedge core_clk);
        #1 if (core_conv_clk_en === 1'b1) n++;
      end
      chk(n[15:0], 16'd128 >> d);
    end
    // ---------------------------------------------------------------
    // pins taken as converter inputs
    // ---------------------------------------------------------------
    @(posedge core_clk);
    pin_analog_sel <= 16'h8001;
    repeat (2) @(posedge core_clk);
    #1 chk(pin_func_release, 16'h8001);
    chk(pin_pullup_off, 16'h8001);
    conclude();
  end
endmodule
